// ---- sp0_regs.vh ----
// register map, field positions and timing counts of serial port zero
`ifndef SP0_REGS_VH
`define SP0_REGS_VH
`define SP0_CTRL_IDX      8'h98
`define SP0_DATA_IDX      8'h99
`define SP0_POWER_CONTROL_REG_IDX      8'h87
`define SP0_SLAVE_MATCH_ADDR_IDX     8'hA9
`define SP0_SLAVE_MATCH_MASK_IDX     8'hB9
`define SP0_IRQ_IDX       8'hC0
`define SP0_MASK_IDX      8'hC1
`define SP0_CTRL_ADDR     12'h260
`define SP0_DATA_ADDR     12'h264
`define SP0_POWER_CONTROL_REG_ADDR     12'h21C
`define SP0_SLAVE_MATCH_ADDR_ADDR    12'h2A4
`define SP0_SLAVE_MATCH_MASK_ADDR    12'h2E4
`define SP0_IRQ_ADDR      12'h300
`define SP0_MASK_ADDR     12'h304
`define SP0_B_M0          7
`define SP0_B_M1          6
`define SP0_B_MP          5
`define SP0_B_REN         4
`define SP0_B_TB8         3
`define SP0_B_RB8         2
`define SP0_B_TI          1
`define SP0_B_RI          0
`define SP0_P_DBL         7
`define SP0_P_FESEL       6
// mode 0 half shift periods, minus one: a bit is two halves
`define SP0_DIV12         4'h5
`define SP0_DIV4          4'h1
`define SP0_DIV_M2        6'h3F
`define SP0_ACC_T1        4'hF
`define SP0_ACC_T1_DBL    4'h7
`define SP0_MID           4'h7
`endif

// ---- sp0_uart.v ----
// serial port zero: mode 0 shift register and modes 1-3 async uart
// Behaviour
// - control bit 7 is mode bit or frame error
// - bad stop bit sets frame error, software clears
// - mode bits choose one of four modes
// - mode 0 shift clock osc/12 or osc/4
// - modes 2/3 multiproc: ninth bit 0 suppresses receive
// - mode 1 multiproc: need valid stop bit
// - reception only while receive enable set
// - modes 2/3 send software ninth bit
// - received ninth bit holds bit9 or stop
// - transmit flag set at bit 8 or stop
// - receive flag set at bit 8 or mid-stop
// - data address: read receive, write transmit
// - baud doubler doubles rate in modes 1-3
// - address compare only where mask bit set
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/100ps
`include "sp0_regs.vh"
module sp0_uart (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        timer_ovf,
    input  wire        rxd_in,
    output reg         rxd_out,
    output reg         rxd_oe,
    output reg         txd_out,
    output reg         irq
);
////////////////////////////////////////////////////////////////////////////
localparam ST_IDLE = 2'b00;
localparam ST_TX   = 2'b01;
localparam ST_RX   = 2'b10;

reg  [7:0]  ctrl_r;
reg  [7:0]  power_control_reg_r;
reg         fe_r;
reg  [7:0]  slave_match_addr_r;
reg  [7:0]  slave_match_mask_r;
reg  [7:0]  rxbuf_r;
reg  [1:0]  irq_st_r;
reg  [1:0]  irq_mk_r;
reg         rx_s1_r;
reg         rx_s2_r;
reg         rx_prev_r;
reg  [3:0]  pre_r;
reg  [5:0]  div2_r;
reg  [3:0]  tx_ph_r;
reg  [3:0]  rx_ph_r;
reg  [1:0]  tx_st_r;
reg  [1:0]  rx_st_r;
reg  [10:0] tx_sh_r;
reg  [3:0]  tx_cnt_r;
reg  [9:0]  rx_sh_r;
reg  [3:0]  rx_cnt_r;
reg         m0_ph_r;

wire        fesel  = power_control_reg_r[`SP0_P_FESEL];
wire        dbl    = power_control_reg_r[`SP0_P_DBL];
wire [1:0]  mode   = {ctrl_r[`SP0_B_M0], ctrl_r[`SP0_B_M1]};
wire        mp     = ctrl_r[`SP0_B_MP];
wire        ren    = ctrl_r[`SP0_B_REN];
wire        wr_en  = psel & penable & pwrite;
wire        rd_en  = psel & ~penable & ~pwrite;
////////////////////////////////////////////////////////////////////////////
// tick generation: 16 ticks per async bit, 8 in modes 1/3 with the doubler
wire [3:0] m0_div = mp ? `SP0_DIV4 : `SP0_DIV12;
wire       m0_tick = (pre_r == m0_div);
wire [5:0] m2_lim = dbl ? 6'h1F : `SP0_DIV_M2;
// 16 ticks per bit: every 4 clocks, every 2 with the doubler,
// so a mode 2 bit lasts 64 or 32 clocks
wire       m2_tick = (mode == 2'b10) &&
                     (dbl ? !div2_r[0] : (div2_r[1:0] == 2'b00));
// timer overflow is one tick; doubler halves ticks per bit in modes 1/3
wire       async_tick = (mode == 2'b10) ? m2_tick : timer_ovf;
wire [3:0] ph_lim = (mode == 2'b10) ? 4'hF
                  : (dbl ? `SP0_ACC_T1_DBL : `SP0_ACC_T1);

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pre_r  <= 4'h0;
        div2_r <= 6'h00;
    end else begin
        pre_r  <= m0_tick ? 4'h0 : pre_r + 4'h1;
        div2_r <= (div2_r >= m2_lim) ? 6'h00 : div2_r + 6'h01;
    end
end
////////////////////////////////////////////////////////////////////////////
// receive address filter
// mode 1 frame is one bit shorter, so its byte sits one place higher
// at the moment the last bit is sampled
wire [7:0] rx_byte = mode[1] ? rx_sh_r[8:1] : rx_sh_r[9:2];
wire       addr_ok = (((rx_byte ^ slave_match_addr_r) & slave_match_mask_r) == 8'h00);
wire       rx_bit  = rx_s2_r;
wire       tx_end  = (tx_st_r == ST_TX);
reg        ri_set;
reg        ti_set;
reg        fe_set;
reg        rb8_set;
reg        rb8_val;
////////////////////////////////////////////////////////////////////////////
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        rx_s1_r   <= 1'b1;
        rx_s2_r   <= 1'b1;
        rx_prev_r <= 1'b1;
    end else begin
        rx_s1_r   <= rxd_in;
        rx_s2_r   <= rx_s1_r;
        rx_prev_r <= rx_s2_r;
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        tx_st_r  <= ST_IDLE;
        rx_st_r  <= ST_IDLE;
        tx_sh_r  <= 11'h7FF;
        tx_cnt_r <= 4'h0;
        rx_sh_r  <= 10'h000;
        rx_cnt_r <= 4'h0;
        tx_ph_r  <= 4'h0;
        rx_ph_r  <= 4'h0;
        m0_ph_r  <= 1'b0;
        rxbuf_r  <= 8'h00;
        txd_out  <= 1'b1;
        rxd_out  <= 1'b1;
        rxd_oe   <= 1'b0;
        ri_set   <= 1'b0;
        ti_set   <= 1'b0;
        fe_set   <= 1'b0;
        rb8_set  <= 1'b0;
        rb8_val  <= 1'b0;
    end else begin
        ri_set  <= 1'b0;
        ti_set  <= 1'b0;
        fe_set  <= 1'b0;
        rb8_set <= 1'b0;
        if (wr_en && paddr == `SP0_DATA_ADDR) begin
            tx_st_r  <= ST_TX;
            tx_cnt_r <= 4'h0;
            tx_ph_r  <= 4'h0;
            m0_ph_r  <= 1'b0;
            // start, data lsb first, ninth or stop, stop
            tx_sh_r  <= {1'b1, ctrl_r[`SP0_B_TB8] | ~mode[1],
                         pwdata[7:0], 1'b0};
            if (mode == 2'b00) begin
                tx_sh_r <= {3'b111, pwdata[7:0]};
                rxd_oe  <= 1'b1;
            end
        end else if (mode == 2'b00 && (tx_end || rx_st_r == ST_RX)) begin
            // shift clock runs for either direction, low half first
            if (m0_tick) begin
                m0_ph_r <= ~m0_ph_r;
                if (!m0_ph_r) begin
                    if (tx_end)
                        rxd_out <= tx_sh_r[0];
                    txd_out <= 1'b0;
                end else begin
                    txd_out <= 1'b1;
                    if (tx_end) begin
                        tx_sh_r  <= {1'b1, tx_sh_r[10:1]};
                        tx_cnt_r <= tx_cnt_r + 4'h1;
                    end
                    // data line keeps its last bit; oe releases the pin
                    if (tx_end && tx_cnt_r == 4'h7) begin
                        tx_st_r <= ST_IDLE;
                        rxd_oe  <= 1'b0;
                        ti_set  <= 1'b1;
                    end
                end
            end
        end else if (tx_end && async_tick) begin
            tx_ph_r <= (tx_ph_r == ph_lim) ? 4'h0 : tx_ph_r + 4'h1;
            if (tx_ph_r == 4'h0) begin
                txd_out  <= tx_sh_r[0];
                tx_sh_r  <= {1'b1, tx_sh_r[10:1]};
                tx_cnt_r <= tx_cnt_r + 4'h1;
                // stop bit is bit 9 in mode 1, bit 10 otherwise
                if (tx_cnt_r == (mode[1] ? 4'hA : 4'h9))
                    ti_set <= 1'b1;
                if (tx_cnt_r == (mode[1] ? 4'hB : 4'hA)) begin
                    tx_st_r <= ST_IDLE;
                    txd_out <= 1'b1;
                end
            end
        end
        // mode 0 receive: clear of ri with ren starts a shift
        if (mode == 2'b00) begin
            if (rx_st_r == ST_IDLE && ren && !ctrl_r[`SP0_B_RI]
                && !tx_end) begin
                rx_st_r  <= ST_RX;
                rx_cnt_r <= 4'h0;
                m0_ph_r  <= 1'b0;
            end else if (rx_st_r == ST_RX && m0_tick && m0_ph_r) begin
                rx_sh_r  <= {rx_bit, rx_sh_r[9:1]};
                rx_cnt_r <= rx_cnt_r + 4'h1;
                if (rx_cnt_r == 4'h7) begin
                    rx_st_r <= ST_IDLE;
                    rxbuf_r <= {rx_bit, rx_sh_r[9:3]};
                    ri_set  <= 1'b1;
                end
            end
        end else if (rx_st_r == ST_IDLE) begin
            if (ren && rx_prev_r && !rx_bit) begin
                rx_st_r  <= ST_RX;
                rx_cnt_r <= 4'h0;
                rx_ph_r  <= 4'h0;
            end
        end else if (async_tick) begin
            rx_ph_r <= (rx_ph_r == ph_lim) ? 4'h0 : rx_ph_r + 4'h1;
            if (rx_ph_r == (ph_lim >> 1)) begin
                rx_cnt_r <= rx_cnt_r + 4'h1;
                rx_sh_r  <= {rx_bit, rx_sh_r[9:1]};
                if (rx_cnt_r == 4'h0 && rx_bit)
                    rx_st_r <= ST_IDLE; // false start
                if (rx_cnt_r == (mode[1] ? 4'hA : 4'h9)) begin
                    rx_st_r <= ST_IDLE;
                    fe_set  <= ~rx_bit;
                    if (!ctrl_r[`SP0_B_RI] &&
                        (!mp || (mode == 2'b01 && rx_bit) ||
                         (mode[1] && rx_sh_r[9] && addr_ok)))
                    begin
                        rxbuf_r <= rx_byte;
                        ri_set  <= 1'b1;
                        rb8_set <= 1'b1;
                        rb8_val <= mode[1] ? rx_sh_r[9] : rx_bit;
                    end
                end
            end
        end
    end
end
////////////////////////////////////////////////////////////////////////////
// software registers; hardware set wins over clear
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        ctrl_r   <= 8'h00;
        fe_r     <= 1'b0;
        power_control_reg_r   <= 8'h00;
        slave_match_addr_r  <= 8'h00;
        slave_match_mask_r  <= 8'h00;
        irq_st_r <= 2'b00;
        irq_mk_r <= 2'b00;
    end else begin
        if (wr_en && paddr == `SP0_CTRL_ADDR) begin
            ctrl_r[7:3] <= {fesel ? ctrl_r[7] : pwdata[7],
                            pwdata[6:3]};
            ctrl_r[2:0] <= pwdata[2:0];
            if (fesel)
                fe_r <= pwdata[7];
        end
        if (wr_en && paddr == `SP0_POWER_CONTROL_REG_ADDR)
            power_control_reg_r <= {pwdata[7:6], 6'h00};
        if (wr_en && paddr == `SP0_SLAVE_MATCH_ADDR_ADDR)
            slave_match_addr_r <= pwdata[7:0];
        if (wr_en && paddr == `SP0_SLAVE_MATCH_MASK_ADDR)
            slave_match_mask_r <= pwdata[7:0];
        if (wr_en && paddr == `SP0_MASK_ADDR)
            irq_mk_r <= pwdata[1:0];
        if (wr_en && paddr == `SP0_IRQ_ADDR)
            irq_st_r <= irq_st_r & ~pwdata[1:0];
        if (ti_set) begin
            ctrl_r[`SP0_B_TI] <= 1'b1;
            irq_st_r[1]       <= 1'b1;
        end
        if (ri_set) begin
            ctrl_r[`SP0_B_RI] <= 1'b1;
            irq_st_r[0]       <= 1'b1;
        end
        if (rb8_set && mode != 2'b00)
            ctrl_r[`SP0_B_RB8] <= rb8_val;
        if (fe_set)
            fe_r <= 1'b1;
    end
end
////////////////////////////////////////////////////////////////////////////
// apb: zero wait, read data registered in setup cycle
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata  <= 32'h00000000;
        pready  <= 1'b0;
        pslverr <= 1'b0;
        irq     <= 1'b0;
    end else begin
        pready  <= psel & ~penable;
        pslverr <= 1'b0;
        irq     <= |(irq_st_r & irq_mk_r);
        if (rd_en) begin
            case (paddr)
            `SP0_CTRL_ADDR:  prdata <= {24'h000000,
                                 fesel ? fe_r : ctrl_r[7],
                                 ctrl_r[6:0]};
            `SP0_DATA_ADDR:  prdata <= {24'h000000, rxbuf_r};
            `SP0_POWER_CONTROL_REG_ADDR:  prdata <= {24'h000000, power_control_reg_r};
            `SP0_SLAVE_MATCH_ADDR_ADDR: prdata <= {24'h000000, slave_match_addr_r};
            `SP0_SLAVE_MATCH_MASK_ADDR: prdata <= {24'h000000, slave_match_mask_r};
            `SP0_IRQ_ADDR:   prdata <= {30'h00000000, irq_st_r};
            `SP0_MASK_ADDR:  prdata <= {30'h00000000, irq_mk_r};
            default:         prdata <= 32'h00000000;
            endcase
        end else if (psel && !penable) begin
            // writes answer with zero data, so unmapped ones read clean
            prdata <= 32'h00000000;
        end
        if (psel && !penable && !(paddr == `SP0_CTRL_ADDR ||
            paddr == `SP0_DATA_ADDR || paddr == `SP0_POWER_CONTROL_REG_ADDR ||
            paddr == `SP0_SLAVE_MATCH_ADDR_ADDR || paddr == `SP0_SLAVE_MATCH_MASK_ADDR ||
            paddr == `SP0_IRQ_ADDR || paddr == `SP0_MASK_ADDR))
            pslverr <= 1'b1;
    end
end

endmodule // sp0_uart

// ---- sp0_uart_properties.sv ----
// port-level checks for serial port zero
`timescale 1ns/100ps
`include "sp0_regs.vh"
module sp0_uart_properties (
    input logic        pclk,
    input logic        presetn,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic        pready,
    input logic        pslverr,
    input logic        timer_ovf,
    input logic        rxd_in,
    input logic        rxd_out,
    input logic        rxd_oe,
    input logic        txd_out,
    input logic        irq
);
logic [1:0] mode_r;
logic [1:0] mask_r;
wire        acc = psel && penable && pwrite && pready;
wire        mapped = paddr == `SP0_CTRL_ADDR || paddr == `SP0_DATA_ADDR
    || paddr == `SP0_POWER_CONTROL_REG_ADDR || paddr == `SP0_SLAVE_MATCH_ADDR_ADDR
    || paddr == `SP0_SLAVE_MATCH_MASK_ADDR || paddr == `SP0_IRQ_ADDR
    || paddr == `SP0_MASK_ADDR;
default clocking cb @(posedge pclk); endclocking
default disable iff (!presetn);
// shadow of mode and mask, updated at the access edge only
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        mode_r <= 2'b00;
        mask_r <= 2'b00;
    end else if (acc && paddr == `SP0_CTRL_ADDR) begin
        mode_r <= pwdata[7:6];
    end else if (acc && paddr == `SP0_MASK_ADDR) begin
        mask_r <= pwdata[1:0];
    end
end
property p_answer; psel && !penable |=> pready; endproperty
a_answer: assert property (p_answer) else $error("no answer");
property p_single; pready |=> !pready; endproperty
a_single: assert property (p_single) else $error("long ready");
property p_unmap; psel && !penable && !mapped |=> pslverr && prdata == 0;
endproperty
a_unmap: assert property (p_unmap) else $error("unmapped");
property p_byte; pready && !pwrite |-> prdata[31:8] == 24'h0; endproperty
a_byte: assert property (p_byte) else $error("upper bits");
property p_no_oe; $past(mode_r) != 2'b00 && mode_r != 2'b00 |-> !rxd_oe;
endproperty
a_no_oe: assert property (p_no_oe) else $error("rxd driven");
property p_start; acc && paddr == `SP0_DATA_ADDR && mode_r[0]
    |-> ##[1:40] !txd_out; endproperty
a_start: assert property (p_start) else $error("no start bit");
property p_irq; $rose(irq) |-> $past(mask_r) != 2'b00; endproperty
a_irq: assert property (p_irq) else $error("masked irq");
property p_idle; $rose(presetn) |-> txd_out && !irq && !pready;
endproperty
a_idle: assert property (p_idle) else $error("not idle");
endmodule // sp0_uart_properties
bind sp0_uart sp0_uart_properties u_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_ovf(timer_ovf), .rxd_in(rxd_in), .rxd_out(rxd_out),
    .rxd_oe(rxd_oe), .txd_out(txd_out), .irq(irq));

// ---- sp0_peer.sv ----
// serial peer: sends frames and captures transmitted ones
`timescale 1ns/100ps
module sp0_peer #(
    parameter BIT = 32
) (
    input  logic pclk,
    input  logic txd_out,
    output logic rxd_in
);
initial rxd_in = 1'b1;
// start, data lsb first, stop; stop level chosen to inject faults
task send(input logic [8:0] d, input int n, input logic stp);
    rxd_in <= 1'b0;
    repeat (BIT) @(posedge pclk);
    for (int i = 0; i < n; i++) begin
        rxd_in <= d[i];
        repeat (BIT) @(posedge pclk);
    end
    rxd_in <= stp;
    repeat (BIT) @(posedge pclk);
    rxd_in <= 1'b1;
endtask
// samples mid-bit, returns before the stop bit
task recv(input int n, output logic [8:0] d);
    d = 9'h000;
    @(negedge txd_out);
    repeat (BIT / 2) @(posedge pclk);
    for (int i = 0; i < n; i++) begin
        repeat (BIT) @(posedge pclk);
        d[i] = txd_out;
    end
endtask
endmodule // sp0_peer

// ---- sp0_uart_tb_top.sv ----
// self-checking bench for serial port zero
`timescale 1ns/100ps
`include "sp0_regs.vh"
module sp0_uart_tb_top;
logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
logic [11:0] paddr = 12'h000;
logic [31:0] pwdata = 32'h0, prdata, rd;
logic        pready, pslverr, timer_ovf = 0, rxd_out, rxd_oe, txd_out;
logic        irq, perr, peer_rxd;
logic [8:0]  got;
logic        m0_on = 0, txd_q = 1;
logic [7:0]  m0_cap = 8'h00;
int          err_count = 0, checks = 0;
wire         rxd_in = rxd_oe ? rxd_out : peer_rxd;
always #50 pclk = ~pclk;
// tick every other clock keeps a bit at 32 clocks
always @(posedge pclk) timer_ovf <= ~timer_ovf;
// mode 0 capture: data taken at each rising shift clock
always @(posedge pclk) begin
    txd_q <= txd_out;
    if (m0_on && txd_out && !txd_q)
        m0_cap <= {rxd_out, m0_cap[7:1]};
end
sp0_uart dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_ovf(timer_ovf), .rxd_in(rxd_in), .rxd_out(rxd_out),
    .rxd_oe(rxd_oe), .txd_out(txd_out), .irq(irq));
sp0_peer #(.BIT(32)) peer (.pclk(pclk), .txd_out(txd_out),
    .rxd_in(peer_rxd));
task finish_test;
    if (err_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
endtask
task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
        err_count++;
        $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
endtask
task rw(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
endtask
initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rw(1'b0, 12'h100, 32'h0);
    chk({31'h0, perr}, 32'h1);
    rw(1'b1, `SP0_MASK_ADDR, 32'h3);
    rw(1'b1, `SP0_CTRL_ADDR, 32'h50);
    fork
        peer.recv(8, got);
        rw(1'b1, `SP0_DATA_ADDR, 32'hA5);
    join
    chk({23'h0, got}, 32'hA5);
    repeat (32) @(posedge pclk);
    rw(1'b0, `SP0_IRQ_ADDR, 32'h0);
    chk(rd, 32'h2);
    rw(1'b0, `SP0_CTRL_ADDR, 32'h0);
    chk(rd, 32'h52);
    rw(1'b1, `SP0_IRQ_ADDR, 32'h3);
    rw(1'b1, `SP0_CTRL_ADDR, 32'h50);
    chk({31'h0, irq}, 32'h0);
    peer.send(9'h03C, 8, 1'b1);
    rw(1'b0, `SP0_DATA_ADDR, 32'h0);
    chk(rd, 32'h3C);
    rw(1'b0, `SP0_CTRL_ADDR, 32'h0);
    chk(rd, 32'h55);
    chk({31'h0, irq}, 32'h1);
    rw(1'b1, `SP0_MASK_ADDR, 32'h0);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    rw(1'b1, `SP0_IRQ_ADDR, 32'h3);
    rw(1'b1, `SP0_MASK_ADDR, 32'h3);
    rw(1'b1, `SP0_POWER_CONTROL_REG_ADDR, 32'h40);
    rw(1'b1, `SP0_CTRL_ADDR, 32'h70);
    peer.send(9'h011, 8, 1'b0);
    rw(1'b0, `SP0_CTRL_ADDR, 32'h0);
    chk(rd, 32'hF0);
    rw(1'b1, `SP0_CTRL_ADDR, 32'h70);
    rw(1'b0, `SP0_CTRL_ADDR, 32'h0);
    chk(rd, 32'h70);
    rw(1'b1, `SP0_POWER_CONTROL_REG_ADDR, 32'h0);
    rw(1'b1, `SP0_CTRL_ADDR, 32'h40);
    peer.send(9'h022, 8, 1'b1);
    rw(1'b0, `SP0_CTRL_ADDR, 32'h0);
    chk(rd, 32'h40);
    rw(1'b1, `SP0_CTRL_ADDR, 32'hD8);
    fork
        peer.recv(9, got);
        rw(1'b1, `SP0_DATA_ADDR, 32'h5A);
    join
    chk({23'h0, got}, 32'h15A);
    repeat (32) @(posedge pclk);
    rw(1'b1, `SP0_IRQ_ADDR, 32'h3);
    rw(1'b1, `SP0_CTRL_ADDR, 32'hF0);
    peer.send(9'h077, 9, 1'b1);
    rw(1'b0, `SP0_CTRL_ADDR, 32'h0);
    chk(rd, 32'hF0);
    peer.send(9'h177, 9, 1'b1);
    rw(1'b0, `SP0_CTRL_ADDR, 32'h0);
    chk(rd, 32'hF5);
    rw(1'b0, `SP0_DATA_ADDR, 32'h0);
    chk(rd, 32'h77);
    rw(1'b1, `SP0_CTRL_ADDR, 32'hF0);
    rw(1'b1, `SP0_SLAVE_MATCH_ADDR_ADDR, 32'h55);
    rw(1'b1, `SP0_SLAVE_MATCH_MASK_ADDR, 32'h0F);
    peer.send(9'h177, 9, 1'b1);
    rw(1'b0, `SP0_CTRL_ADDR, 32'h0);
    chk(rd, 32'hF0);
    peer.send(9'h165, 9, 1'b1);
    rw(1'b0, `SP0_CTRL_ADDR, 32'h0);
    chk(rd, 32'hF5);
    rw(1'b1, `SP0_POWER_CONTROL_REG_ADDR, 32'h80);
    rw(1'b1, `SP0_IRQ_ADDR, 32'h3);
    rw(1'b1, `SP0_CTRL_ADDR, 32'h98);
    fork
        peer.recv(9, got);
        rw(1'b1, `SP0_DATA_ADDR, 32'h3C);
    join
    chk({23'h0, got}, 32'h13C);
    repeat (32) @(posedge pclk);
    rw(1'b1, `SP0_CTRL_ADDR, 32'h00);
    rw(1'b1, `SP0_IRQ_ADDR, 32'h3);
    m0_on <= 1'b1;
    rw(1'b1, `SP0_DATA_ADDR, 32'h96);
    repeat (120) @(posedge pclk);
    chk({24'h0, m0_cap}, 32'h96);
    rw(1'b0, `SP0_CTRL_ADDR, 32'h0);
    chk(rd, 32'h02);
    finish_test;
end
// roughly five times the expected run
initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    finish_test;
end
endmodule // sp0_uart_tb_top
